// ==== ctp_pkg.sv ====
package ctp_pkg;
    // cache-op codes in instruction bits [20:18]
    localparam logic [2:0] CTP_OP_LOAD_TAG   = 3'h1;
    localparam logic [2:0] CTP_OP_STORE_TAG  = 3'h2;
    localparam logic [2:0] CTP_OP_STORE_DATA = 3'h3;
    // cache selector in instruction bits [17:16]
    localparam logic [1:0] CTP_CACHE_I = 2'h0;
    localparam logic [1:0] CTP_CACHE_D = 2'h1;
    localparam logic [5:0] CTP_PREFETCH_INSTR_OPCODE = 6'h33;
    // prefetch hints
    localparam logic [4:0] CTP_HINT_LOAD      = 5'h00;
    localparam logic [4:0] CTP_HINT_STORE     = 5'h01;
    localparam logic [4:0] CTP_HINT_LOAD_STR  = 5'h04;
    localparam logic [4:0] CTP_HINT_STORE_STR = 5'h05;
    localparam logic [4:0] CTP_HINT_LOAD_RET  = 5'h06;
    localparam logic [4:0] CTP_HINT_STORE_RET = 5'h07;
    localparam logic [4:0] CTP_HINT_NUDGE     = 5'h19;
    localparam logic [4:0] CTP_HINT_ZERO      = 5'h1e;
    localparam logic [4:0] CTP_HINT_FASTPREP  = 5'h1f;
    // register offsets on the avalon slave (word addresses)
    localparam logic [3:0] CTP_REG_CTRL    = 4'h0;
    localparam logic [3:0] CTP_REG_TAG_LOW_REG   = 4'h1;
    localparam logic [3:0] CTP_REG_TAG_LOW_SECONDARY_REG  = 4'h2;
    localparam logic [3:0] CTP_REG_DATALO  = 4'h3;
    localparam logic [3:0] CTP_REG_STATUS  = 4'h4;
    localparam logic [3:0] CTP_REG_LOCK    = 4'h5;
    localparam logic [3:0] CTP_REG_LRU     = 4'h6;
    // control register field positions
    localparam int CTP_CTRL_SPR = 0;
    localparam int CTP_CTRL_DYT = 1;
    localparam int CTP_CTRL_WST = 2;
    localparam int CTP_CTRL_CU0 = 3;
    localparam logic [31:0] CTP_CTRL_RESET = 32'h0000_0008;
    localparam logic [31:0] CTP_ZERO32     = 32'h0000_0000;
    // prefetch action codes
    typedef enum logic [2:0] {
        CTP_PF_NONE  = 3'b000,
        CTP_PF_LOAD  = 3'b001,
        CTP_PF_STORE = 3'b010,
        CTP_PF_NUDGE = 3'b011,
        CTP_PF_ZERO  = 3'b100,
        CTP_PF_VALID = 3'b101
    } ctp_pf_t;
    typedef enum logic [1:0] {
        CTP_WAY_LRU   = 2'b00,
        CTP_WAY_ZERO  = 2'b01,
        CTP_WAY_NOT0  = 2'b10
    } ctp_way_t;
endpackage : ctp_pkg

// ==== ctp_test_ram.sv ====
`timescale 1ns/10ps
`default_nettype none
module ctp_test_ram #(
    parameter int AW = 6,
    parameter int DW = 32
) (
    input  wire logic          clock,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : ctp_test_ram
`default_nettype wire

// ==== ctp_cache_test.sv ====
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - spr mode op1 reads scratch tag to tag1
// - spr mode op2 writes tag_low into scratch tag
// - spr mode op3 writes data_low into scratch data
// - scratch data parity always computed, no override
// - test bits ignored for icache ops
// - dirty mode needs dyt set, spr wst clear
// - dirty mode op1 reads dirty ram to tag1
// - dirty mode op2 writes tag1 into dirty ram
// - cop0 disabled gives coprocessor unusable
// - prefetch address base plus signext offset
// - prefetch raises no address exceptions
// - prefetch bus/cache errors reported by choice
// - uncached prefetch does nothing
// - prefetch uses effective address attribute
// - hint0 load, hint1 store
// - hints 2 and 3 are nops
// - hint4 streamed load into way0
// - way0 locked uses replacement pointer
// - hint5 streamed store, 6/7 avoid way0
// - hint25 writeback then invalidate, locked untouched
// - hint30 zero fill, hint31 validate on miss
module ctp_cache_test
    import ctp_pkg::*;
#(
    parameter int          IDX_W     = 6,
    parameter int          WAYS      = 4,
    parameter logic        REPORT_BE = 1'b1
) (
    input  wire logic        clock,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // pipeline: instruction issue
    input  wire logic        instr_valid,
    input  wire logic        instr_is_cache,
    input  wire logic [31:0] instr_word,
    input  wire logic [31:0] base_value,
    // pipeline: translation result for the effective address
    input  wire logic        xlat_fault,
    input  wire logic        xlat_uncached,
    input  wire logic [2:0]  xlat_cca,
    input  wire logic        line_hit,
    input  wire logic        line_dirty,
    input  wire logic        line_locked,
    input  wire logic        pf_bus_error,
    // results
    output logic             cpu_exc_r,
    output logic             pf_exc_r,
    output logic             pf_req_r,
    output ctp_pf_t          pf_action_r,
    output logic      [31:0] pf_addr_r,
    output logic      [2:0]  pf_cca_r,
    output logic      [1:0]  pf_way_r,
    output logic             done_r
);
    //////////////////////////////////////////////////////////////////////////
    function automatic logic parity32(input logic [31:0] d);
        return ^d;
    endfunction : parity32

    function automatic logic [1:0] way_pick(input ctp_way_t mode, input logic [3:0] locks,
                                            input logic [1:0] replacement_history);
        logic [1:0] w;
        w = replacement_history;
        if (mode == CTP_WAY_ZERO) begin
            w = locks[0] ? replacement_history : 2'h0;
        end else if (mode == CTP_WAY_NOT0) begin
            w = (replacement_history == 2'h0) ? 2'h1 : replacement_history;
        end
        return w;
    endfunction : way_pick

    //////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_r;
    logic [31:0] tag_low_reg_r;
    logic [31:0] tag_low_secondary_reg_r;
    logic [31:0] datalo_r;
    logic [3:0]  lock_r;
    logic [1:0]  lru_r;
    logic        rd_pend_r;
    logic        ram_rd_r;
    logic        ram_rd_dirty_r;
    logic        spr_par_r;

    wire logic [5:0]  opcode   = instr_word[31:26];
    wire logic [2:0]  cop      = instr_word[20:18];
    wire logic [1:0]  csel     = instr_word[17:16];
    wire logic [4:0]  hint     = instr_word[20:16];
    wire logic [31:0] eff_addr = base_value + {{16{instr_word[15]}}, instr_word[15:0]};
    wire logic [IDX_W-1:0] idx = eff_addr[IDX_W+1:2];

    wire logic spr_sel = ctrl_r[CTP_CTRL_SPR];
    wire logic dyt_sel = ctrl_r[CTP_CTRL_DYT];
    wire logic wst_sel = ctrl_r[CTP_CTRL_WST];
    wire logic cu0_en  = ctrl_r[CTP_CTRL_CU0];
    wire logic spr_mode = spr_sel & ~dyt_sel & ~wst_sel;
    wire logic dyt_mode = dyt_sel & ~spr_sel & ~wst_sel;

    wire logic is_cache = instr_valid & instr_is_cache;
    wire logic is_prefetch_instr  = instr_valid & ~instr_is_cache & (opcode == CTP_PREFETCH_INSTR_OPCODE);
    wire logic cache_ok = is_cache & cu0_en;
    wire logic dcache   = cache_ok & (csel == CTP_CACHE_D);
    wire logic spr_op   = dcache & spr_mode;
    wire logic dyt_op   = dcache & dyt_mode;

    wire logic spr_tag_ld  = spr_op & (cop == CTP_OP_LOAD_TAG);
    wire logic spr_tag_st  = spr_op & (cop == CTP_OP_STORE_TAG);
    wire logic spr_dat_st  = spr_op & (cop == CTP_OP_STORE_DATA);
    wire logic dyt_ld      = dyt_op & (cop == CTP_OP_LOAD_TAG);
    wire logic dyt_st      = dyt_op & (cop == CTP_OP_STORE_TAG);

    //////////////////////////////////////////////////////////////////////////
    // test rams: scratchpad tag, scratchpad data with parity, dirty bits
    logic [31:0] sp_tag_q;
    logic [32:0] sp_dat_q;
    logic [31:0] dirty_q;

    ctp_test_ram #(.AW(IDX_W), .DW(32)) u_sp_tag (
        .clock (clock),
        .we    (spr_tag_st),
        .waddr (idx),
        .wdata (tag_low_reg_r),
        .raddr (idx),
        .rdata (sp_tag_q)
    );
    ctp_test_ram #(.AW(IDX_W), .DW(33)) u_sp_dat (
        .clock (clock),
        .we    (spr_dat_st),
        .waddr (idx),
        .wdata ({parity32(datalo_r), datalo_r}),
        .raddr (idx),
        .rdata (sp_dat_q)
    );
    ctp_test_ram #(.AW(IDX_W), .DW(32)) u_dirty (
        .clock (clock),
        .we    (dyt_st),
        .waddr (idx),
        .wdata (tag_low_secondary_reg_r),
        .raddr (idx),
        .rdata (dirty_q)
    );

    //////////////////////////////////////////////////////////////////////////
    // prefetch decode
    ctp_pf_t  pf_act;
    ctp_way_t pf_wmode;
    always_comb begin
        pf_act   = CTP_PF_NONE;
        pf_wmode = CTP_WAY_LRU;
        unique case (hint)
            CTP_HINT_LOAD:      pf_act = CTP_PF_LOAD;
            CTP_HINT_STORE:     pf_act = CTP_PF_STORE;
            CTP_HINT_LOAD_STR: begin
                pf_act   = CTP_PF_LOAD;
                pf_wmode = CTP_WAY_ZERO;
            end
            CTP_HINT_STORE_STR: begin
                pf_act   = CTP_PF_STORE;
                pf_wmode = CTP_WAY_ZERO;
            end
            CTP_HINT_LOAD_RET: begin
                pf_act   = CTP_PF_LOAD;
                pf_wmode = CTP_WAY_NOT0;
            end
            CTP_HINT_STORE_RET: begin
                pf_act   = CTP_PF_STORE;
                pf_wmode = CTP_WAY_NOT0;
            end
            CTP_HINT_NUDGE:     pf_act = line_locked ? CTP_PF_NONE : CTP_PF_NUDGE;
            CTP_HINT_ZERO:      pf_act = line_hit ? CTP_PF_NONE : CTP_PF_ZERO;
            CTP_HINT_FASTPREP:  pf_act = line_hit ? CTP_PF_NONE : CTP_PF_VALID;
            default:            pf_act = CTP_PF_NONE;
        endcase
    end

    // fetches request even on a hit; nudge ignores line_dirty and checks only line_locked
    wire logic pf_blocked = xlat_fault | xlat_uncached;
    wire logic pf_go      = is_prefetch_instr & ~pf_blocked & (pf_act != CTP_PF_NONE);
    wire logic [1:0] pf_way = way_pick(pf_wmode, lock_r, lru_r);

    always_ff @(posedge clock) begin
        if (reset) begin
            cpu_exc_r   <= 1'b0;
            pf_exc_r    <= 1'b0;
            pf_req_r    <= 1'b0;
            pf_action_r <= CTP_PF_NONE;
            pf_addr_r   <= CTP_ZERO32;
            pf_cca_r    <= 3'h0;
            pf_way_r    <= 2'h0;
            done_r      <= 1'b0;
        end else begin
            cpu_exc_r   <= is_cache & ~cu0_en;
            pf_exc_r    <= is_prefetch_instr & REPORT_BE & pf_bus_error & ~pf_blocked;
            pf_req_r    <= pf_go;
            pf_action_r <= pf_go ? pf_act : CTP_PF_NONE;
            pf_addr_r   <= eff_addr;
            pf_cca_r    <= xlat_cca;
            pf_way_r    <= pf_way;
            done_r      <= instr_valid;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // avalon slave: writes complete at once, reads take one wait cycle
    wire logic sel_ctrl   = avs_address == CTP_REG_CTRL;
    wire logic sel_tag_low_reg  = avs_address == CTP_REG_TAG_LOW_REG;
    wire logic sel_tag_low_secondary_reg = avs_address == CTP_REG_TAG_LOW_SECONDARY_REG;
    wire logic sel_datalo = avs_address == CTP_REG_DATALO;
    wire logic sel_lock   = avs_address == CTP_REG_LOCK;
    wire logic sel_lru    = avs_address == CTP_REG_LRU;
    wire logic [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire logic [31:0] wmerge_ctrl = (ctrl_r & ~bmask) | (avs_writedata & bmask);

    assign avs_waitrequest = avs_read & ~rd_pend_r;

    logic [31:0] rd_mux;
    always_comb begin
        unique case (avs_address)
            CTP_REG_CTRL:   rd_mux = ctrl_r;
            CTP_REG_TAG_LOW_REG:  rd_mux = tag_low_reg_r;
            CTP_REG_TAG_LOW_SECONDARY_REG: rd_mux = tag_low_secondary_reg_r;
            CTP_REG_DATALO: rd_mux = datalo_r;
            CTP_REG_STATUS: rd_mux = {29'h0, spr_par_r, spr_mode, dyt_mode};
            CTP_REG_LOCK:   rd_mux = {28'h0, lock_r};
            CTP_REG_LRU:    rd_mux = {30'h0, lru_r};
            default:        rd_mux = CTP_ZERO32;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rd_pend_r    <= 1'b0;
            avs_readdata <= CTP_ZERO32;
        end else begin
            rd_pend_r    <= avs_read & ~rd_pend_r;
            avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_r         <= CTP_CTRL_RESET;
            tag_low_reg_r        <= CTP_ZERO32;
            datalo_r       <= CTP_ZERO32;
            lock_r         <= 4'h0;
            lru_r          <= 2'h0;
        end else if (avs_write) begin
            if (sel_ctrl)   ctrl_r   <= wmerge_ctrl;
            if (sel_tag_low_reg)  tag_low_reg_r  <= avs_writedata;
            if (sel_datalo) datalo_r <= avs_writedata;
            if (sel_lock)   lock_r   <= avs_writedata[3:0];
            if (sel_lru)    lru_r    <= avs_writedata[1:0];
        end
    end

    // tag1 is loaded by test reads one cycle after the ram is addressed;
    // a hardware load wins over a simultaneous bus write
    always_ff @(posedge clock) begin
        if (reset) begin
            ram_rd_r       <= 1'b0;
            ram_rd_dirty_r <= 1'b0;
            tag_low_secondary_reg_r       <= CTP_ZERO32;
            spr_par_r      <= 1'b0;
        end else begin
            ram_rd_r       <= spr_tag_ld | dyt_ld;
            ram_rd_dirty_r <= dyt_ld;
            if (ram_rd_r && !ram_rd_dirty_r) spr_par_r <= sp_dat_q[32];
            if (ram_rd_r) begin
                tag_low_secondary_reg_r <= ram_rd_dirty_r ? dirty_q : sp_tag_q;
            end else if (avs_write && sel_tag_low_secondary_reg) begin
                tag_low_secondary_reg_r <= avs_writedata;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    property p_cu_exc;
        @(posedge clock) disable iff (reset)
        (is_cache && !cu0_en) |=> cpu_exc_r;
    endproperty
    a_cu_exc: assert property (p_cu_exc) else $error("no cop unusable exception");

    property p_uncached;
        @(posedge clock) disable iff (reset)
        (is_prefetch_instr && (xlat_uncached || xlat_fault)) |=> !pf_req_r;
    endproperty
    a_uncached: assert property (p_uncached) else $error("blocked prefetch made request");

    property p_stream_way;
        @(posedge clock) disable iff (reset)
        (pf_go && hint == CTP_HINT_LOAD_STR && !lock_r[0]) |=> (pf_way_r == 2'h0);
    endproperty
    a_stream_way: assert property (p_stream_way) else $error("streamed load not in way0");

    property p_locked_way;
        @(posedge clock) disable iff (reset)
        (pf_go && hint == CTP_HINT_STORE_STR && lock_r[0]) |=> (pf_way_r == $past(lru_r));
    endproperty
    a_locked_way: assert property (p_locked_way) else $error("locked way0 not using lru");

    property p_retained;
        @(posedge clock) disable iff (reset)
        (pf_go && (hint == CTP_HINT_LOAD_RET || hint == CTP_HINT_STORE_RET)) |=> (pf_way_r != 2'h0);
    endproperty
    a_retained: assert property (p_retained) else $error("retained hint chose way0");

    property p_reserved;
        @(posedge clock) disable iff (reset)
        (is_prefetch_instr && (hint == 5'h02 || hint == 5'h03)) |=> !pf_req_r;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved hint acted");

    property p_hit_nop;
        @(posedge clock) disable iff (reset)
        (is_prefetch_instr && line_hit && (hint == CTP_HINT_ZERO || hint == CTP_HINT_FASTPREP)) |=> !pf_req_r;
    endproperty
    a_hit_nop: assert property (p_hit_nop) else $error("prepare hint acted on hit");

    property p_addr;
        @(posedge clock) disable iff (reset)
        pf_go |=> (pf_addr_r == $past(base_value) + {{16{$past(instr_word[15])}}, $past(instr_word[15:0])});
    endproperty
    a_addr: assert property (p_addr) else $error("prefetch address wrong");

    property p_icache_ignores;
        @(posedge clock) disable iff (reset)
        (cache_ok && csel == CTP_CACHE_I) |=> !ram_rd_r;
    endproperty
    a_icache_ignores: assert property (p_icache_ignores) else $error("icache op used test ram");

    property p_tag_load;
        @(posedge clock) disable iff (reset)
        (spr_tag_ld || dyt_ld) |=> ram_rd_r ##1 (tag_low_secondary_reg_r == $past(ram_rd_dirty_r ? dirty_q : sp_tag_q));
    endproperty
    a_tag_load: assert property (p_tag_load) else $error("tag1 not loaded from test ram");
endmodule : ctp_cache_test
`default_nettype wire

// ==== ctp_pipe_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ctp_pipe_model
    import ctp_pkg::*;
(
    input  wire logic        clock,
    output logic             instr_valid,
    output logic             instr_is_cache,
    output logic      [31:0] instr_word,
    output logic      [31:0] base_value,
    output logic             xlat_fault,
    output logic             xlat_uncached,
    output logic      [2:0]  xlat_cca,
    output logic             line_hit,
    output logic             line_dirty,
    output logic             line_locked,
    output logic             pf_bus_error
);
    initial begin
        {instr_valid, instr_is_cache, instr_word, base_value} = '0;
        {xlat_fault, xlat_uncached, xlat_cca, line_hit, line_dirty, line_locked, pf_bus_error} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // x = {fault, uncached, cca[2:0], hit, dirty, locked, bus_error}
    task automatic issue(input logic c, input logic [31:0] w, input logic [31:0] b, input logic [8:0] x);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_is_cache <= c;
        instr_word <= w;
        base_value <= b;
        {xlat_fault, xlat_uncached, xlat_cca, line_hit, line_dirty, line_locked, pf_bus_error} <= x;
        @(posedge clock);
        instr_valid <= 1'b0;
        // operands are stale once taken, so scramble them
        instr_word <= ~w;
        base_value <= ~b;
        {xlat_fault, xlat_uncached, xlat_cca, line_hit, line_dirty, line_locked, pf_bus_error} <= ~x;
    endtask : issue
    // only the three test codes, d-cache or i-cache, index in the cached unmapped segment
    task automatic cache_op(input logic [2:0] op, input logic [1:0] sel, input int idx);
        issue(1'b1, {6'h2f, 5'h00, op, sel, 16'h0000}, 32'h8000_0000 | (32'(idx) << 2), 9'h000);
    endtask : cache_op
endmodule : ctp_pipe_model
`default_nettype wire

// ==== cache_test_access_prefetch_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module cache_test_access_prefetch_test
    import ctp_pkg::*;
;
    logic clock, reset, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, base_value, instr_word, pf_addr;
    logic instr_valid, instr_is_cache, xlat_fault, xlat_uncached, line_hit, line_dirty, line_locked;
    logic pf_bus_error, cpu_exc, pf_exc, pf_req, done;
    logic [2:0] xlat_cca, pf_cca;
    logic [1:0] pf_way;
    ctp_pf_t pf_action;
    int n_fail, n_tests;
    logic [31:0] ctrl, lock, replacement_history, rd, v;
    logic [31:0] tag_m [64];
    logic [31:0] dirty_m [64];
    logic [31:0] data_m [64];
    int idx_q [$];
    logic [8:0] x;
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    ctp_pipe_model i_pipe (.clock(clock), .instr_valid(instr_valid), .instr_is_cache(instr_is_cache),
        .instr_word(instr_word), .base_value(base_value), .xlat_fault(xlat_fault),
        .xlat_uncached(xlat_uncached), .xlat_cca(xlat_cca), .line_hit(line_hit), .line_dirty(line_dirty),
        .line_locked(line_locked), .pf_bus_error(pf_bus_error));
    ctp_cache_test #(.IDX_W(6), .WAYS(4), .REPORT_BE(1'b1)) i_dut (.clock(clock), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .instr_valid(instr_valid), .instr_is_cache(instr_is_cache),
        .instr_word(instr_word), .base_value(base_value), .xlat_fault(xlat_fault),
        .xlat_uncached(xlat_uncached), .xlat_cca(xlat_cca), .line_hit(line_hit), .line_dirty(line_dirty),
        .line_locked(line_locked), .pf_bus_error(pf_bus_error), .cpu_exc_r(cpu_exc), .pf_exc_r(pf_exc),
        .pf_req_r(pf_req), .pf_action_r(pf_action), .pf_addr_r(pf_addr), .pf_cca_r(pf_cca),
        .pf_way_r(pf_way), .done_r(done));
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        avs_write <= w;
        avs_read <= ~w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clock);
        end while (avs_waitrequest);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
        if (a == CTP_REG_CTRL) ctrl = d;
    endtask : wr
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        bus(1'b0, a, 32'h0, rd);
        check(what, exp, rd & m);
    endtask : rd_chk
    task automatic cop(input logic [2:0] op, input logic [1:0] sel, input int idx);
        i_pipe.cache_op(op, sel, idx);
        @(negedge clock);
        check("cache exc", {31'h0, ~ctrl[CTP_CTRL_CU0]}, {31'h0, cpu_exc});
        check("cache req", 32'h0, {31'h0, pf_req});
        repeat (2) @(posedge clock);
    endtask : cop
    function automatic void pf_model(input logic [4:0] h, input logic [8:0] x,
                                     output logic rq, output logic [2:0] ac, output logic [1:0] w);
        rq = 1'b0;
        ac = CTP_PF_NONE;
        w = replacement_history[1:0];
        if (!x[8] && !x[7]) begin
            case (h)
                0, 1, 4, 5, 6, 7: begin
                    rq = 1'b1;
                    ac = h[0] ? CTP_PF_STORE : CTP_PF_LOAD;
                end
                25: if (!x[1]) begin
                    rq = 1'b1;
                    ac = CTP_PF_NUDGE;
                end
                30, 31: if (!x[3]) begin
                    rq = 1'b1;
                    ac = h[0] ? CTP_PF_VALID : CTP_PF_ZERO;
                end
                default: ;
            endcase
        end
        if (h == 4 || h == 5) w = lock[0] ? replacement_history[1:0] : 2'h0;
        if (h == 6 || h == 7) w = (replacement_history[1:0] == 2'h0) ? 2'h1 : replacement_history[1:0];
    endfunction : pf_model
    task automatic pf(input logic [4:0] h, input logic [31:0] b, input logic [15:0] o, input logic [8:0] x);
        logic rq;
        logic [2:0] ac;
        logic [1:0] w;
        pf_model(h, x, rq, ac, w);
        i_pipe.issue(1'b0, {CTP_PREFETCH_INSTR_OPCODE, 5'h00, h, o}, b, x);
        @(negedge clock);
        check("pf req", {31'h0, rq}, {31'h0, pf_req});
        check("pf action", {29'h0, ac}, {29'h0, pf_action});
        check("pf exc", {31'h0, x[0]}, {31'h0, pf_exc});
        check("pf done", 32'h1, {31'h0, done});
        if (rq) check("pf addr", b + {{16{o[15]}}, o}, pf_addr);
        if (rq) check("pf cca", {29'h0, x[6:4]}, {29'h0, pf_cca});
        if (ac == CTP_PF_LOAD || ac == CTP_PF_STORE) check("pf way", {30'h0, w}, {30'h0, pf_way});
    endtask : pf
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge clock);
        n_fail++;
        report_and_stop();
    end
    initial begin
        reset = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        void'($urandom(81987));
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        rd_chk("ctrl reset", CTP_REG_CTRL, CTP_CTRL_RESET, 32'hffff_ffff);
        ctrl = CTP_CTRL_RESET;
        wr(4'hf, $urandom);
        rd_chk("unmapped", 4'hf, 32'h0, 32'hffff_ffff);
        foreach (dirty_m[i]) v = 0;
        for (int k = 1; k <= 6; k++) begin
            v = $urandom;
            wr(4'(k), v);
            if (k != 4) rd_chk("reg rw", 4'(k), v & (k == 5 ? 32'hf : k == 6 ? 32'h3 : 32'hffff_ffff), 32'hffff_ffff);
        end
        for (int m = 0; m < 8; m++) begin
            wr(CTP_REG_CTRL, 32'h8 | m);
            rd_chk("mode decode", CTP_REG_STATUS, {30'h0, m == 1, m == 2}, 32'h3);
        end
        wr(CTP_REG_CTRL, 32'h9);
        for (int k = 0; k < 6; k++) begin
            idx_q.push_back($urandom_range(63));
            tag_m[idx_q[k]] = $urandom;
            wr(CTP_REG_TAG_LOW_REG, tag_m[idx_q[k]]);
            cop(CTP_OP_STORE_TAG, CTP_CACHE_D, idx_q[k]);
            data_m[idx_q[k]] = $urandom;
            wr(CTP_REG_DATALO, data_m[idx_q[k]]);
            cop(CTP_OP_STORE_DATA, CTP_CACHE_D, idx_q[k]);
        end
        foreach (idx_q[k]) begin
            cop(CTP_OP_LOAD_TAG, CTP_CACHE_D, idx_q[k]);
            rd_chk("scratch tag", CTP_REG_TAG_LOW_SECONDARY_REG, tag_m[idx_q[k]], 32'hffff_ffff);
            rd_chk("scratch parity", CTP_REG_STATUS, {29'h0, ^data_m[idx_q[k]], 2'b10}, 32'h7);
        end
        wr(CTP_REG_TAG_LOW_SECONDARY_REG, 32'h5a5a_0f0f);
        cop(CTP_OP_LOAD_TAG, CTP_CACHE_I, idx_q[0]);
        rd_chk("icache op", CTP_REG_TAG_LOW_SECONDARY_REG, 32'h5a5a_0f0f, 32'hffff_ffff);
        wr(CTP_REG_CTRL, 32'ha);
        foreach (idx_q[k]) begin
            dirty_m[idx_q[k]] = $urandom & 32'hf;
            wr(CTP_REG_TAG_LOW_SECONDARY_REG, dirty_m[idx_q[k]]);
            cop(CTP_OP_STORE_TAG, CTP_CACHE_D, idx_q[k]);
        end
        foreach (idx_q[k]) begin
            wr(CTP_REG_TAG_LOW_SECONDARY_REG, 32'h0);
            cop(CTP_OP_LOAD_TAG, CTP_CACHE_D, idx_q[k]);
            rd_chk("dirty ram", CTP_REG_TAG_LOW_SECONDARY_REG, dirty_m[idx_q[k]], 32'hffff_ffff);
        end
        wr(CTP_REG_CTRL, 32'hb);
        wr(CTP_REG_TAG_LOW_SECONDARY_REG, 32'h0000_00a5);
        cop(CTP_OP_LOAD_TAG, CTP_CACHE_D, idx_q[0]);
        rd_chk("two modes", CTP_REG_TAG_LOW_SECONDARY_REG, 32'h0000_00a5, 32'hffff_ffff);
        wr(CTP_REG_CTRL, 32'h1);
        cop(CTP_OP_LOAD_TAG, CTP_CACHE_D, idx_q[0]);
        wr(CTP_REG_CTRL, 32'h8);
        for (int i = 0; i < 96; i++) begin
            lock = $urandom & 32'hf;
            replacement_history = $urandom & 32'h3;
            wr(CTP_REG_LOCK, lock);
            wr(CTP_REG_LRU, replacement_history);
            x = 9'($urandom) & 9'h1fe;
            if ($urandom_range(3) != 0) x[8:7] = 2'b00;
            if (i % 32 < 30) x[3] = 1'b0;
            if (i % 32 == 0 && x[8:7] == 2'b00) x[0] = 1'($urandom_range(1));
            pf(5'(i), $urandom, 16'($urandom), x);
        end
        report_and_stop();
    end
endmodule : cache_test_access_prefetch_test
`default_nettype wire
